// File: rtl/rre_pkg.sv
/*
 Shared constants for the return and rotate execution unit: operation codes,
 widths, reset values and the interrupt vector.
 Assumes nothing of its surroundings; imported whole by the design modules.
*/
`default_nettype none

package rre_pkg;

   // ----------------------------------------------------------------------
   // Widths and depths
   // ----------------------------------------------------------------------
   localparam int DATA_W = 8;
   localparam int PC_W = 12;
   localparam int STACK_DEPTH = 8;
   localparam int LVL_W = 4;
   localparam int PTR_W = 3;

   // ----------------------------------------------------------------------
   // Bit positions
   // ----------------------------------------------------------------------
   localparam int MSB_POS = 7;
   localparam int LSB_POS = 0;

   // ----------------------------------------------------------------------
   // Reset values and fixed addresses
   // ----------------------------------------------------------------------
   localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
   localparam logic [PC_W-1:0] PC_RST = 12'h000;
   localparam logic [PC_W-1:0] IRQ_VECTOR = 12'h004;
   localparam logic [LVL_W-1:0] LVL_EMPTY = 4'h0;
   localparam logic [LVL_W-1:0] LVL_FULL = 4'h8;
   localparam logic [LVL_W-1:0] LVL_ONE = 4'h1;
   localparam logic CARRY_RST = 1'b0;
   localparam logic GIE_RST = 1'b0;

   // ----------------------------------------------------------------------
   // Operation codes from decode
   // ----------------------------------------------------------------------
   typedef enum logic [3:0] {
      OP_NONE = 4'h0,
      OP_RETURN_WITH_LITERAL = 4'h1,
      OP_RETURN_FROM_INTERRUPT = 4'h2,
      OP_ROTATE_LEFT_IN_PLACE = 4'h3,
      OP_ROTATE_LEFT_TO_ACCUMULATOR = 4'h4,
      OP_ROTATE_LEFT_THROUGH_FLAG_IN_PLACE = 4'h5,
      OP_ROTATE_LEFT_THROUGH_FLAG_TO_ACCUMULATOR = 4'h6,
      OP_ROTATE_RIGHT_IN_PLACE = 4'h7,
      OP_ROTATE_RIGHT_TO_ACCUMULATOR = 4'h8,
      OP_ROTATE_RIGHT_THROUGH_FLAG_IN_PLACE = 4'h9
   } rre_op_e;

   // ----------------------------------------------------------------------
   // Sequencer states
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_RUN = 2'b01,
      ST_VECTOR = 2'b10
   } rre_state_e;

endpackage : rre_pkg

`default_nettype wire

// File: rtl/rre_rotator.sv
/*
 One-place byte rotator, left or right, plain or through the carry flag.
 Purely combinational; the caller registers the result and the carry.
*/
`default_nettype none

module rre_rotator
   import rre_pkg::*;
(
   // Operand
   input wire logic [DATA_W-1:0] data_in,
   input wire logic carry_in,
   // Mode
   input wire logic rot_left,
   input wire logic through_carry,
   // Result
   output logic [DATA_W-1:0] data_out,
   output logic carry_out
);

   logic left_fill;
   logic right_fill;

   // ----------------------------------------------------------------------
   // Fill bits: the wrapped-around bit, or the old carry for the nine-bit ring
   // ----------------------------------------------------------------------
   assign left_fill = through_carry ? carry_in : data_in[MSB_POS];
   assign right_fill = through_carry ? carry_in : data_in[LSB_POS];

   always_comb begin
      if (rot_left) begin
         data_out = {data_in[MSB_POS-1:LSB_POS], left_fill};
         carry_out = through_carry ? data_in[MSB_POS] : carry_in;
      end else begin
         data_out = {right_fill, data_in[MSB_POS:LSB_POS+1]};
         carry_out = through_carry ? data_in[LSB_POS] : carry_in;
      end
   end

endmodule // rre_rotator

`default_nettype wire

// File: rtl/rre_exec.sv
/*
 Execution unit for the return and rotate operations of an 8-bit core.
 Holds the accumulator, carry flag, global interrupt enable, the return stack
 and the restored program counter. Decode presents one operation per enabled
 cycle with its memory operand already read; data memory writes leave as a
 registered write strobe. Calls are pushed by the partner through push_valid.
*/
`default_nettype none

module rre_exec
   import rre_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Operation from decode
   input wire logic op_valid,
   input wire rre_op_e op_code,
   input wire logic [DATA_W-1:0] op_imm,
   input wire logic [DATA_W-1:0] mem_rdata,
   input wire logic [DATA_W-1:0] mem_addr,
   // Call push from decode
   input wire logic push_valid,
   input wire logic [PC_W-1:0] push_addr,
   // Interrupt request
   input wire logic irq_pending,
   // Program counter redirect
   output logic pc_load,
   output logic [PC_W-1:0] pc_out,
   // Data memory write
   output logic mem_we,
   output logic [DATA_W-1:0] mem_waddr,
   output logic [DATA_W-1:0] mem_wdata,
   // Core state
   output logic [DATA_W-1:0] acc_out,
   output logic carry_out,
   output logic global_interrupt_enable,
   output logic [LVL_W-1:0] stack_level,
   // Status
   output logic irq_ack,
   output logic stack_fault
);

   // ----------------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------------
   logic [PC_W-1:0] stack_mem [STACK_DEPTH];
   logic [LVL_W-1:0] level_reg;
   logic [DATA_W-1:0] acc_reg;
   logic carry_reg;
   logic gie_reg;
   logic [PC_W-1:0] pc_reg;
   logic pc_load_reg;
   logic mem_we_reg;
   logic [DATA_W-1:0] mem_waddr_reg;
   logic [DATA_W-1:0] mem_wdata_reg;
   logic irq_ack_reg;
   logic fault_reg;
   rre_state_e state_reg;
   rre_state_e state_next;

   // ----------------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------------
   logic run;
   logic do_ret_lit;
   logic do_return_from_interrupt;
   logic do_pop;
   logic do_rot;
   logic rot_left;
   logic rot_carry;
   logic rot_to_acc;
   logic irq_take;
   logic do_push;
   logic [PC_W-1:0] push_value;
   logic [PC_W-1:0] top_value;
   logic [PTR_W-1:0] top_ptr;
   logic [PTR_W-1:0] push_ptr;
   logic [DATA_W-1:0] rot_result;
   logic rot_carry_out;

   assign run = (state_reg == ST_RUN);
   assign do_ret_lit = run && op_valid && (op_code == OP_RETURN_WITH_LITERAL);
   assign do_return_from_interrupt = run && op_valid && (op_code == OP_RETURN_FROM_INTERRUPT);
   assign do_pop = do_ret_lit || do_return_from_interrupt;

   always_comb begin
      do_rot = run && op_valid;
      rot_left = 1'b1;
      rot_carry = 1'b0;
      rot_to_acc = 1'b0;
      case (op_code)
         OP_ROTATE_LEFT_IN_PLACE: begin
         end
         OP_ROTATE_LEFT_TO_ACCUMULATOR: begin
            rot_to_acc = 1'b1;
         end
         OP_ROTATE_LEFT_THROUGH_FLAG_IN_PLACE: begin
            rot_carry = 1'b1;
         end
         OP_ROTATE_LEFT_THROUGH_FLAG_TO_ACCUMULATOR: begin
            rot_carry = 1'b1;
            rot_to_acc = 1'b1;
         end
         OP_ROTATE_RIGHT_IN_PLACE: begin
            rot_left = 1'b0;
         end
         OP_ROTATE_RIGHT_TO_ACCUMULATOR: begin
            rot_left = 1'b0;
            rot_to_acc = 1'b1;
         end
         OP_ROTATE_RIGHT_THROUGH_FLAG_IN_PLACE: begin
            rot_left = 1'b0;
            rot_carry = 1'b1;
         end
         default: begin
            do_rot = 1'b0;
         end
      endcase
   end

   rre_rotator u_rotator (
      .data_in(mem_rdata),
      .carry_in(carry_reg),
      .rot_left(rot_left),
      .through_carry(rot_carry),
      .data_out(rot_result),
      .carry_out(rot_carry_out)
   );

   // ----------------------------------------------------------------------
   // Interrupt sequencing
   // ----------------------------------------------------------------------
   // A request seen with the return from interrupt is taken right after it,
   // so the handler runs again before the interrupted code resumes.
   assign irq_take = run && irq_pending && ((gie_reg && !op_valid) || do_return_from_interrupt);

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_RUN: begin
            if (irq_take) begin
               state_next = ST_VECTOR;
            end
         end
         ST_VECTOR: begin
            state_next = ST_RUN;
         end
         default: begin
            state_next = ST_RUN;
         end
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg <= ST_RUN;
      end else begin
         state_reg <= state_next;
      end
   end

   // ----------------------------------------------------------------------
   // Return stack
   // ----------------------------------------------------------------------
   // The vector cycle pushes the address just restored (or current PC),
   // so a chained handler returns to the main program.
   assign do_push = (state_reg == ST_VECTOR) || (run && push_valid && !do_pop);
   assign push_value = (state_reg == ST_VECTOR) ? pc_reg : push_addr;
   assign top_ptr = PTR_W'(level_reg - LVL_ONE);
   assign push_ptr = level_reg[PTR_W-1:0];
   assign top_value = stack_mem[top_ptr];

   always_ff @(posedge clk) begin
      if (do_push && (level_reg != LVL_FULL)) begin
         stack_mem[push_ptr] <= push_value;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         level_reg <= LVL_EMPTY;
         fault_reg <= 1'b0;
      end else begin
         fault_reg <= 1'b0;
         if (do_pop) begin
            if (level_reg != LVL_EMPTY) begin
               level_reg <= level_reg - LVL_ONE;
            end else begin
               fault_reg <= 1'b1;
            end
         end else if (do_push) begin
            if (level_reg != LVL_FULL) begin
               level_reg <= level_reg + LVL_ONE;
            end else begin
               fault_reg <= 1'b1;
            end
         end
      end
   end

   // ----------------------------------------------------------------------
   // Program counter and interrupt enable
   // ----------------------------------------------------------------------
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pc_reg <= PC_RST;
         pc_load_reg <= 1'b0;
         gie_reg <= GIE_RST;
         irq_ack_reg <= 1'b0;
      end else begin
         pc_load_reg <= 1'b0;
         irq_ack_reg <= 1'b0;
         if (state_reg == ST_VECTOR) begin
            pc_reg <= IRQ_VECTOR;
            pc_load_reg <= 1'b1;
            gie_reg <= 1'b0;
            irq_ack_reg <= 1'b1;
         end else if (do_pop && (level_reg != LVL_EMPTY)) begin
            // A pop on an empty stack has nothing to restore, so PC and enable stay put
            pc_reg <= top_value;
            pc_load_reg <= 1'b1;
            if (do_return_from_interrupt) begin
               gie_reg <= 1'b1;
            end
         end
      end
   end

   // ----------------------------------------------------------------------
   // Accumulator, carry and memory write-back
   // ----------------------------------------------------------------------
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         acc_reg <= ACC_RST;
         carry_reg <= CARRY_RST;
      end else begin
         if (do_ret_lit) begin
            acc_reg <= op_imm;
         end else if (do_rot && rot_to_acc) begin
            acc_reg <= rot_result;
         end
         // Plain rotates pass the carry through unchanged
         if (do_rot) begin
            carry_reg <= rot_carry_out;
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         mem_we_reg <= 1'b0;
         mem_waddr_reg <= ACC_RST;
         mem_wdata_reg <= ACC_RST;
      end else begin
         mem_we_reg <= do_rot && !rot_to_acc;
         if (do_rot && !rot_to_acc) begin
            mem_waddr_reg <= mem_addr;
            mem_wdata_reg <= rot_result;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign pc_load = pc_load_reg;
   assign pc_out = pc_reg;
   assign mem_we = mem_we_reg;
   assign mem_waddr = mem_waddr_reg;
   assign mem_wdata = mem_wdata_reg;
   assign acc_out = acc_reg;
   assign carry_out = carry_reg;
   assign global_interrupt_enable = gie_reg;
   assign stack_level = level_reg;
   assign irq_ack = irq_ack_reg;
   assign stack_fault = fault_reg;

endmodule // rre_exec

`default_nettype wire

// File: testbench/rre_mem_model.sv
/*
 Data memory on the far side of the unit: combinational read, one write port.
 Assumes the bench preloads operand bytes through the array by name.
*/
`default_nettype none
module rre_mem_model (
   // Read port
   input wire logic [7:0] addr,
   output logic [7:0] rdata,
   // Write port
   input wire logic clk,
   input wire logic we,
   input wire logic [7:0] waddr,
   input wire logic [7:0] wdata
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem [256];
   assign rdata = mem[addr];
   always @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end
endmodule // rre_mem_model
`default_nettype wire

// File: testbench/rre_exec_asserts.sv
/*
 Assertions on the ports of the execution unit.
 Assumes a bind from the testbench top; one clock domain.
*/
`default_nettype none
module rre_exec_chk
   import rre_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Operation side
   input wire logic op_valid,
   input wire rre_op_e op_code,
   input wire logic [DATA_W-1:0] op_imm,
   input wire logic [DATA_W-1:0] mem_rdata,
   input wire logic irq_pending,
   // Results
   input wire logic pc_load,
   input wire logic [PC_W-1:0] pc_out,
   input wire logic mem_we,
   input wire logic [DATA_W-1:0] mem_wdata,
   input wire logic [DATA_W-1:0] acc_out,
   input wire logic carry_out,
   input wire logic global_interrupt_enable,
   input wire logic [LVL_W-1:0] stack_level,
   input wire logic irq_ack
);
   timeunit 1ns;
   timeprecision 1ns;
   // Operands one cycle back; a vector cycle swallows the op, hence the irq_ack escapes
   logic [DATA_W-1:0] d_q;
   logic [DATA_W-1:0] i_q;
   logic c_q;
   always_ff @(posedge clk) begin
      d_q <= mem_rdata;
      i_q <= op_imm;
      c_q <= carry_out;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   property p_rot(rre_op_e op, logic we, logic [DATA_W-1:0] val, logic c);
      op_valid && op_code == op |=> irq_ack || (mem_we == we && (we ? mem_wdata : acc_out) == val && carry_out == c);
   endproperty
   sequence s_ret;
      op_valid && stack_level != LVL_EMPTY;
   endsequence
   a_ret_literal: assert property (s_ret and op_code == OP_RETURN_WITH_LITERAL |=>
      irq_ack || (pc_load && acc_out == i_q && carry_out == c_q)) else $error("literal return wrong");
   a_return_from_interrupt_sets_gie: assert property (s_ret and op_code == OP_RETURN_FROM_INTERRUPT |=>
      irq_ack || (pc_load && global_interrupt_enable)) else $error("interrupt return wrong");
   a_return_from_interrupt_pending_first: assert property (s_ret and op_code == OP_RETURN_FROM_INTERRUPT && irq_pending
      |-> ##[1:2] (irq_ack && pc_out == IRQ_VECTOR)) else $error("pending interrupt not taken");
   a_rl_in_place: assert property (p_rot(OP_ROTATE_LEFT_IN_PLACE, 1'b1, {d_q[6:0], d_q[7]}, c_q))
      else $error("left rotate in place wrong");
   a_rl_to_acc: assert property (p_rot(OP_ROTATE_LEFT_TO_ACCUMULATOR, 1'b0, {d_q[6:0], d_q[7]}, c_q))
      else $error("left rotate to acc wrong");
   a_rlc_in_place: assert property (p_rot(OP_ROTATE_LEFT_THROUGH_FLAG_IN_PLACE, 1'b1, {d_q[6:0], c_q}, d_q[7]))
      else $error("left carry rotate in place wrong");
   a_rlc_to_acc: assert property (p_rot(OP_ROTATE_LEFT_THROUGH_FLAG_TO_ACCUMULATOR, 1'b0, {d_q[6:0], c_q}, d_q[7]))
      else $error("left carry rotate to acc wrong");
   a_rr_in_place: assert property (p_rot(OP_ROTATE_RIGHT_IN_PLACE, 1'b1, {d_q[0], d_q[7:1]}, c_q))
      else $error("right rotate in place wrong");
   a_rr_to_acc: assert property (p_rot(OP_ROTATE_RIGHT_TO_ACCUMULATOR, 1'b0, {d_q[0], d_q[7:1]}, c_q))
      else $error("right rotate to acc wrong");
   a_rrc_in_place: assert property (p_rot(OP_ROTATE_RIGHT_THROUGH_FLAG_IN_PLACE, 1'b1, {c_q, d_q[7:1]}, d_q[0]))
      else $error("right carry rotate in place wrong");
   a_pop_one: assert property (s_ret and (op_code == OP_RETURN_WITH_LITERAL || op_code == OP_RETURN_FROM_INTERRUPT)
      |=> irq_ack || stack_level == $past(stack_level) - LVL_ONE) else $error("return pop count wrong");
   c_vector: cover property (pc_load && irq_ack);
   c_write: cover property (mem_we);
   c_gie: cover property ($rose(global_interrupt_enable));
endmodule // rre_exec_chk
`default_nettype wire

// File: testbench/testbench.sv
/*
 Self-checking bench for the return and rotate execution unit.
 Assumes rre_pkg, the unit, the memory model and the checker are compiled first.
*/
`default_nettype none
module testbench
   import rre_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic op_valid = 1'b0;
   rre_op_e op_code = OP_NONE;
   logic [DATA_W-1:0] op_imm = 8'h00;
   logic [DATA_W-1:0] mem_addr = 8'h00;
   logic [DATA_W-1:0] mem_rdata, mem_waddr, mem_wdata, acc_out;
   logic push_valid = 1'b0;
   logic [PC_W-1:0] push_addr = 12'h000;
   logic [PC_W-1:0] pc_out;
   logic irq_pending = 1'b0;
   logic pc_load, mem_we, carry_out, global_interrupt_enable, irq_ack, stack_fault;
   logic [LVL_W-1:0] stack_level;
   logic cy = CARRY_RST;
   logic [DATA_W-1:0] ac = ACC_RST;
   int tests_run = 0;
   int bad_count = 0;
   always #50 clk = ~clk;
   rre_exec DUT (.clk(clk), .sys_rst(sys_rst), .op_valid(op_valid), .op_code(op_code), .op_imm(op_imm),
      .mem_rdata(mem_rdata), .mem_addr(mem_addr), .push_valid(push_valid), .push_addr(push_addr),
      .irq_pending(irq_pending), .pc_load(pc_load), .pc_out(pc_out), .mem_we(mem_we), .mem_waddr(mem_waddr),
      .mem_wdata(mem_wdata), .acc_out(acc_out), .carry_out(carry_out),
      .global_interrupt_enable(global_interrupt_enable), .stack_level(stack_level), .irq_ack(irq_ack),
      .stack_fault(stack_fault));
   rre_mem_model MEM (.addr(mem_addr), .rdata(mem_rdata), .clk(clk), .we(mem_we), .waddr(mem_waddr),
      .wdata(mem_wdata));
   task automatic chk(input string what, input logic [2*DATA_W-1:0] exp, input logic [2*DATA_W-1:0] got);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Results are sampled at the falling edge, where the registered answer has settled
   task automatic issue(input rre_op_e code, input logic [DATA_W-1:0] imm, input logic [DATA_W-1:0] a);
      @(posedge clk);
      op_valid <= 1'b1;
      op_code <= code;
      op_imm <= imm;
      mem_addr <= a;
      @(posedge clk);
      op_valid <= 1'b0;
      @(negedge clk);
   endtask
   task automatic push(input logic [PC_W-1:0] a);
      @(posedge clk);
      push_valid <= 1'b1;
      push_addr <= a;
      @(posedge clk);
      push_valid <= 1'b0;
   endtask
   task automatic t_rotates;
      rre_op_e code;
      logic [DATA_W-1:0] v, r, a;
      logic c;
      for (int n = 0; n < 14; n++) begin
         code = rre_op_e'(4'(3 + n % 7));
         // Operands vary so every accumulator load and carry update shows a change
         v = 8'(8'h81 + 8'h35 * n);
         a = 8'(8'h10 + n);
         MEM.mem[a] = v;
         c = cy;
         case (code)
            OP_ROTATE_LEFT_IN_PLACE, OP_ROTATE_LEFT_TO_ACCUMULATOR: r = {v[6:0], v[7]};
            OP_ROTATE_RIGHT_IN_PLACE, OP_ROTATE_RIGHT_TO_ACCUMULATOR: r = {v[0], v[7:1]};
            OP_ROTATE_RIGHT_THROUGH_FLAG_IN_PLACE: begin
               r = {cy, v[7:1]};
               c = v[0];
            end
            default: begin
               r = {v[6:0], cy};
               c = v[7];
            end
         endcase
         issue(code, 8'h00, a);
         cy = c;
         if (!code[0]) ac = r;
         chk("rotate write strobe", PC_W'(code[0]), PC_W'(mem_we));
         chk("rotate accumulator", PC_W'(ac), PC_W'(acc_out));
         chk("rotate carry", PC_W'(cy), PC_W'(carry_out));
         if (code[0]) chk("rotate write data", {a, r}, {mem_waddr, mem_wdata});
      end
      $display("rotate test done");
   endtask
   task automatic t_ret_lit;
      push(12'h123);
      issue(OP_RETURN_WITH_LITERAL, 8'h5A, 8'h00);
      chk("literal pc", 12'h123, pc_out);
      chk("literal load and acc", 12'h15A, {3'b000, pc_load, acc_out});
      chk("literal carry", PC_W'(cy), PC_W'(carry_out));
      chk("literal level", 12'h000, PC_W'(stack_level));
      issue(OP_RETURN_WITH_LITERAL, 8'h11, 8'h00);
      chk("empty pop", 12'h001, PC_W'({stack_level, stack_fault}));
      chk("empty pop pc", 12'h123, pc_out);
      $display("literal return test done");
   endtask
   task automatic t_return_from_interrupt;
      push(12'h200);
      irq_pending <= 1'b1;
      issue(OP_RETURN_FROM_INTERRUPT, 8'h00, 8'h00);
      chk("return_from_interrupt pc", 12'h200, pc_out);
      chk("return_from_interrupt gie and level", 12'h010, PC_W'({global_interrupt_enable, stack_level}));
      // The acknowledge stands for one cycle only, right after the vector cycle
      @(negedge clk);
      chk("pending taken", 12'h004, pc_out);
      chk("vector ack", 12'h101, PC_W'({irq_ack, 3'b000, global_interrupt_enable, stack_level}));
      @(posedge clk);
      irq_pending <= 1'b0;
      issue(OP_RETURN_FROM_INTERRUPT, 8'h00, 8'h00);
      chk("resume pc", 12'h200, pc_out);
      repeat (2) @(negedge clk);
      chk("no second vector", 12'h001, PC_W'({irq_ack, global_interrupt_enable}));
      // Idle request with interrupts enabled: current address is pushed, then restored
      @(posedge clk);
      irq_pending <= 1'b1;
      @(posedge clk);
      irq_pending <= 1'b0;
      repeat (2) @(negedge clk);
      chk("idle vector pc", 12'h004, pc_out);
      chk("idle vector ack", 12'h101, PC_W'({irq_ack, 3'b000, global_interrupt_enable, stack_level}));
      issue(OP_RETURN_FROM_INTERRUPT, 8'h00, 8'h00);
      chk("idle resume pc", 12'h200, pc_out);
      chk("idle resume gie and level", 12'h010, PC_W'({global_interrupt_enable, stack_level}));
      $display("interrupt return test done");
   endtask
   task automatic complete_run;
      $display("Checks %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      @(negedge clk);
      chk("reset state", 12'h000, {pc_out[3:0], acc_out}); // Reset values
      t_rotates();
      t_ret_lit();
      t_return_from_interrupt();
      complete_run();
   end
   // Hang guard: a run that outlives this counts as a mismatch
   initial begin
      #500000;
      bad_count++;
      complete_run();
   end
endmodule // testbench
bind rre_exec rre_exec_chk CHK (.clk(clk), .sys_rst(sys_rst), .op_valid(op_valid), .op_code(op_code),
   .op_imm(op_imm), .mem_rdata(mem_rdata), .irq_pending(irq_pending), .pc_load(pc_load), .pc_out(pc_out),
   .mem_we(mem_we), .mem_wdata(mem_wdata), .acc_out(acc_out), .carry_out(carry_out),
   .global_interrupt_enable(global_interrupt_enable), .stack_level(stack_level), .irq_ack(irq_ack));
`default_nettype wire
